/* hdl/tc18_pkg.sv */
// Package with register map, field layout and timing constants of the 18-bit timer/counter.
package tc18_pkg;

  // ----------------------------------------------------------------
  // Register indices; byte address is index times four (printed offsets are not all multiples of four)
  // ----------------------------------------------------------------
  localparam logic [7:0]  IDX_COUNTER_CONTROL = 8'h14;
  localparam logic [7:0]  IDX_GATE_CONTROL    = 8'h15;
  localparam logic [7:0]  IDX_COUNTER_STATUS  = 8'h16;
  localparam logic [7:0]  IDX_COMPARE_LOW     = 8'h17;
  localparam logic [7:0]  IDX_COMPARE_MIDDLE  = 8'h18;
  localparam logic [7:0]  IDX_COMPARE_HIGH    = 8'h19;
  localparam logic [7:0]  IDX_GATE_PERIOD     = 8'h1A;
  localparam logic [7:0]  IDX_CLOCK_CONFIG    = 8'h1B;
  localparam int unsigned ADDR_W              = 10;

  // ----------------------------------------------------------------
  // Reset values and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] COUNTER_CONTROL_RST = 8'h88;
  localparam logic [7:0] GATE_CONTROL_RST    = 8'h02;
  localparam logic [7:0] GATE_PERIOD_RST     = 8'h00;
  localparam int unsigned COUNT_W            = 18;
  localparam int unsigned CLEAR_BIT          = 7;
  localparam int unsigned RUN_HI             = 6;
  localparam int unsigned RUN_LO             = 5;
  localparam int unsigned SRC_HI             = 4;
  localparam int unsigned SRC_LO             = 2;
  localparam int unsigned MODE_HI            = 1;
  localparam int unsigned MODE_LO            = 0;
  localparam int unsigned GSRC_HI            = 6;
  localparam int unsigned GSRC_LO            = 5;
  localparam int unsigned EDGE_BIT           = 4;
  localparam int unsigned GCLK_HI            = 3;
  localparam int unsigned GCLK_LO            = 2;
  localparam int unsigned STAT_RUN_BIT       = 7;
  localparam int unsigned STAT_OVF_BIT       = 6;
  localparam logic [7:0]  GATE_CTRL_KEEP     = 8'h7C;
  localparam logic [7:0]  GATE_CTRL_FORCE    = 8'h02;
  localparam logic [1:0]  COMPARE_HIGH_MASK  = 2'h3;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] RUN_STOP      = 2'h0;
  localparam logic [1:0] RUN_START     = 2'h2;
  localparam logic [1:0] MODE_TIMER    = 2'h0;
  localparam logic [1:0] MODE_PULSE    = 2'h2;
  localparam logic [1:0] MODE_FREQ     = 2'h3;
  localparam logic [1:0] GSRC_PIN      = 2'h0;
  localparam logic [1:0] GSRC_INTERNAL = 2'h1;
  localparam logic [2:0] SRC_FAST      = 3'h0;
  localparam logic [2:0] SRC_SLOW      = 3'h1;
  localparam logic [2:0] SRC_PIN       = 3'h7;
  localparam logic [1:0] AXI_OKAY      = 2'h0;
  localparam logic [1:0] AXI_SLVERR    = 2'h2;

  // ----------------------------------------------------------------
  // Prescaler tap positions: a tap n ticks every 2^n source cycles
  // ----------------------------------------------------------------
  localparam int unsigned FC_DIV_W  = 24;
  localparam int unsigned FS_DIV_W  = 16;
  localparam int unsigned TAP_FC23  = 23;
  localparam int unsigned TAP_FC13  = 13;
  localparam int unsigned TAP_FC11  = 11;
  localparam int unsigned TAP_FC7   = 7;
  localparam int unsigned TAP_FC3   = 3;
  localparam int unsigned TAP_FS15  = 15;
  localparam int unsigned TAP_FS5   = 5;
  localparam int unsigned TAP_FS3   = 3;
  localparam int unsigned TAP_GFC12 = 12;
  localparam int unsigned TAP_GFS4  = 4;
  localparam logic [4:0]  GATE_SPAN = 5'h10;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } axil_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_s;

endpackage : tc18_pkg

/* hdl/tc18_timer.sv */
// 18-bit up-counting timer/counter with AXI4-Lite register access.
//
// Functional notes
// - Clear bit zero clears counter, and overflow unless the counter overflows that cycle; self-sets.
// - Run field 00 stops, 10 starts.
// - Source select maps eight clocks, prescaler bit.
// - Mode field: timer, reserved, pulse, frequency.
// - Low compare byte write blocks match.
// - Compare address reads live counter.
// - Compare high byte bits 7..2 read zero.
// - 18-bit compare and 8-bit gate period.
// - Gate select 01 uses internal gate.
// - Gate base clock 2^12..2^14 fc or 2^4..2^6 fs.
// - Gate high/low last (16 minus setting) periods.
// - Counting flag set while running in frequency mode with gate high.
// - Status resets zero; overflow bit 6.
// - Counter control resets to 1000 1000.
// - Gate select 00 uses count pin.
// - Edge select: falling only or both edges.
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps

module tc18_timer #(
  parameter int unsigned COUNT_W = tc18_pkg::COUNT_W
) (
  input  wire logic               SYS_CLK,
  input  wire logic               RST,
  input  wire tc18_pkg::axil_req_s AXI_REQ,
  output tc18_pkg::axil_rsp_s      AXI_RSP,
  input  wire logic               FS_TICK,
  input  wire logic               LOW_POWER,
  input  wire logic               EXTERNAL_COUNT_PIN,
  output logic                    COUNTER_INTERRUPT
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W_L = tc18_pkg::ADDR_W;

  typedef struct packed {
    logic [7:0]         ctrl;
    logic [7:0]         gctrl;
    logic [7:0]         period;
    logic               prescaler_source_bit;
    logic [COUNT_W-1:0] compare;
    logic [COUNT_W-1:0] count;
    logic               overflow_flag;
    logic               match_block;
    logic               pin_meta;
    logic               pin_sync;
    logic               pin_last;
    logic               gate_last;
    logic [tc18_pkg::FC_DIV_W-1:0] fc_div;
    logic [tc18_pkg::FS_DIV_W-1:0] fs_div;
    logic               igate;
    logic [3:0]         gate_cnt;
    logic               irq;
    logic               aw_done;
    logic               w_done;
    logic [ADDR_W_L-1:0] awaddr;
    logic [31:0]        wdata;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               rvalid;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
  } state_s;

  state_s s_q;
  state_s s_d;
  logic [1:0] run_f;
  logic [2:0] src_f;
  logic [1:0] mode_f;
  logic       running;
  logic       fc_src_tick;
  logic       fs_src_tick;
  logic       src_tick;
  logic       gate_tick;
  logic       gate;
  logic       fall_pin;
  logic [ADDR_W_L-1:0] wa;
  logic [ADDR_W_L-1:0] ra;
  logic       do_write;
  logic [COUNT_W-1:0] cnt_next;

  assign run_f  = s_q.ctrl[tc18_pkg::RUN_HI:tc18_pkg::RUN_LO];
  assign src_f  = s_q.ctrl[tc18_pkg::SRC_HI:tc18_pkg::SRC_LO];
  assign mode_f = s_q.ctrl[tc18_pkg::MODE_HI:tc18_pkg::MODE_LO];
  assign running = (run_f == tc18_pkg::RUN_START);

  // A tap ticks when all bits below it are ones, one cycle in 2^n.
  function automatic logic fc_tap(input logic [tc18_pkg::FC_DIV_W-1:0] d, input int unsigned n);
    fc_tap = &(d | ~((tc18_pkg::FC_DIV_W'(1) << n) - tc18_pkg::FC_DIV_W'(1)));
  endfunction : fc_tap

  function automatic logic fs_tap(input logic [tc18_pkg::FS_DIV_W-1:0] d, input int unsigned n);
    fs_tap = &(d | ~((tc18_pkg::FS_DIV_W'(1) << n) - tc18_pkg::FS_DIV_W'(1)));
  endfunction : fs_tap

  // ----------------------------------------------------------------
  // Source clock selection
  // ----------------------------------------------------------------
  assign fall_pin    = s_q.pin_last & ~s_q.pin_sync;
  assign fs_src_tick = FS_TICK;
  always_comb begin
    fc_src_tick = 1'b0;
    case (src_f)
      3'h0:    fc_src_tick = 1'b1;
      3'h1:    fc_src_tick = fs_src_tick;
      3'h2:    fc_src_tick = s_q.prescaler_source_bit ?
                             fs_src_tick & fs_tap(s_q.fs_div, tc18_pkg::TAP_FS15) :
                             fc_tap(s_q.fc_div, tc18_pkg::TAP_FC23);
      3'h3:    fc_src_tick = s_q.prescaler_source_bit ?
                             fs_src_tick & fs_tap(s_q.fs_div, tc18_pkg::TAP_FS5) :
                             fc_tap(s_q.fc_div, tc18_pkg::TAP_FC13);
      3'h4:    fc_src_tick = s_q.prescaler_source_bit ?
                             fs_src_tick & fs_tap(s_q.fs_div, tc18_pkg::TAP_FS3) :
                             fc_tap(s_q.fc_div, tc18_pkg::TAP_FC11);
      3'h5:    fc_src_tick = fc_tap(s_q.fc_div, tc18_pkg::TAP_FC7);
      3'h6:    fc_src_tick = fc_tap(s_q.fc_div, tc18_pkg::TAP_FC3);
      3'h7:    fc_src_tick = fall_pin;
      default: fc_src_tick = 1'b0;
    endcase
  end
  assign src_tick = fc_src_tick;

  always_comb begin
    gate_tick = 1'b0;
    if (!LOW_POWER && !s_q.prescaler_source_bit) begin
      case (s_q.gctrl[tc18_pkg::GCLK_HI:tc18_pkg::GCLK_LO])
        2'h0:    gate_tick = fc_tap(s_q.fc_div, tc18_pkg::TAP_GFC12);
        2'h1:    gate_tick = fc_tap(s_q.fc_div, tc18_pkg::TAP_GFC12 + 1);
        2'h2:    gate_tick = fc_tap(s_q.fc_div, tc18_pkg::TAP_GFC12 + 2);
        default: gate_tick = 1'b0;
      endcase
    end else begin
      case (s_q.gctrl[tc18_pkg::GCLK_HI:tc18_pkg::GCLK_LO])
        2'h0:    gate_tick = fs_src_tick & fs_tap(s_q.fs_div, tc18_pkg::TAP_GFS4);
        2'h1:    gate_tick = fs_src_tick & fs_tap(s_q.fs_div, tc18_pkg::TAP_GFS4 + 1);
        2'h2:    gate_tick = fs_src_tick & fs_tap(s_q.fs_div, tc18_pkg::TAP_GFS4 + 2);
        default: gate_tick = 1'b0;
      endcase
    end
  end

  always_comb begin
    case (s_q.gctrl[tc18_pkg::GSRC_HI:tc18_pkg::GSRC_LO])
      tc18_pkg::GSRC_PIN:      gate = s_q.pin_sync;
      tc18_pkg::GSRC_INTERNAL: gate = s_q.igate;
      default:                 gate = 1'b0;
    endcase
  end

  assign wa       = s_q.awaddr;
  assign ra       = AXI_REQ.araddr[ADDR_W_L-1:0];
  assign do_write = s_q.aw_done & s_q.w_done & ~s_q.bvalid;
  assign cnt_next = s_q.count + COUNT_W'(1);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d          = s_q;
    s_d.irq      = 1'b0;
    s_d.pin_meta = EXTERNAL_COUNT_PIN;
    s_d.pin_sync = s_q.pin_meta;
    s_d.pin_last = s_q.pin_sync;
    s_d.fc_div   = s_q.fc_div + tc18_pkg::FC_DIV_W'(1);
    if (FS_TICK) begin
      s_d.fs_div = s_q.fs_div + tc18_pkg::FS_DIV_W'(1);
    end
    s_d.gate_last = gate;

    // internal gate: (16 - setting) base periods per phase
    if (!running) begin
      s_d.igate    = 1'b1;
      s_d.gate_cnt = 4'h0;
    end else if (gate_tick) begin
      if (5'(s_q.gate_cnt) + 5'h1 >= tc18_pkg::GATE_SPAN -
          5'(s_q.igate ? s_q.period[7:4] : s_q.period[3:0])) begin
        s_d.igate    = ~s_q.igate;
        s_d.gate_cnt = 4'h0;
      end else begin
        s_d.gate_cnt = s_q.gate_cnt + 4'h1;
      end
    end

    if (running && src_tick) begin
      case (mode_f)
        tc18_pkg::MODE_TIMER: begin
          if (!s_q.match_block && cnt_next == s_q.compare) begin
            s_d.count = '0;
            s_d.irq   = 1'b1;
          end else begin
            s_d.count = cnt_next;
          end
        end
        tc18_pkg::MODE_PULSE, tc18_pkg::MODE_FREQ: begin
          if (gate) begin
            s_d.count = cnt_next;
            if (&s_q.count) begin
              s_d.overflow_flag = 1'b1;
            end
          end
        end
        default: s_d.count = s_q.count;
      endcase
    end
    if (running && mode_f[1] && (s_q.gate_last != gate) &&
        (s_q.gctrl[tc18_pkg::EDGE_BIT] || s_q.gate_last)) begin
      s_d.irq = 1'b1;
    end

    // AXI4-Lite write side: address and data may arrive in either order.
    if (AXI_REQ.awvalid && !s_q.aw_done) begin
      s_d.aw_done = 1'b1;
      s_d.awaddr  = AXI_REQ.awaddr[ADDR_W_L-1:0];
    end
    if (AXI_REQ.wvalid && !s_q.w_done) begin
      s_d.w_done = 1'b1;
      s_d.wdata  = AXI_REQ.wdata;
    end
    if (do_write) begin
      s_d.bvalid = 1'b1;
      s_d.bresp  = tc18_pkg::AXI_OKAY;
      if (!AXI_REQ.wstrb[0]) begin
        s_d.bresp = tc18_pkg::AXI_OKAY;
      end else if (wa == {tc18_pkg::IDX_COUNTER_CONTROL, 2'h0}) begin
        s_d.ctrl = s_q.wdata[7:0];
        s_d.ctrl[tc18_pkg::CLEAR_BIT] = 1'b1;
        if (!s_q.wdata[tc18_pkg::CLEAR_BIT]) begin
          s_d.count         = '0;
          s_d.overflow_flag = running & src_tick & mode_f[1] & gate & (&s_q.count);
        end
      end else if (wa == {tc18_pkg::IDX_GATE_CONTROL, 2'h0}) begin
        s_d.gctrl = (s_q.wdata[7:0] & tc18_pkg::GATE_CTRL_KEEP) | tc18_pkg::GATE_CTRL_FORCE;
      end else if (wa == {tc18_pkg::IDX_COMPARE_LOW, 2'h0}) begin
        s_d.compare[7:0] = s_q.wdata[7:0];
        s_d.match_block  = 1'b1;
      end else if (wa == {tc18_pkg::IDX_COMPARE_MIDDLE, 2'h0}) begin
        s_d.compare[15:8] = s_q.wdata[7:0];
        s_d.match_block   = 1'b1;
      end else if (wa == {tc18_pkg::IDX_COMPARE_HIGH, 2'h0}) begin
        s_d.compare[COUNT_W-1:16] = s_q.wdata[1:0] & tc18_pkg::COMPARE_HIGH_MASK;
        s_d.match_block           = 1'b0;
      end else if (wa == {tc18_pkg::IDX_GATE_PERIOD, 2'h0}) begin
        s_d.period = s_q.wdata[7:0];
      end else if (wa == {tc18_pkg::IDX_CLOCK_CONFIG, 2'h0}) begin
        s_d.prescaler_source_bit = s_q.wdata[0];
      end else if (wa != {tc18_pkg::IDX_COUNTER_STATUS, 2'h0}) begin
        s_d.bresp = tc18_pkg::AXI_SLVERR;
      end
    end
    if (s_q.bvalid && AXI_REQ.bready) begin
      s_d.bvalid  = 1'b0;
      s_d.aw_done = 1'b0;
      s_d.w_done  = 1'b0;
    end

    // AXI4-Lite read side, one cycle after the address is taken.
    if (AXI_REQ.arvalid && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = tc18_pkg::AXI_OKAY;
      s_d.rdata  = 32'h0;
      if (ra == {tc18_pkg::IDX_COUNTER_CONTROL, 2'h0}) begin
        s_d.rdata[7:0] = s_q.ctrl;
      end else if (ra == {tc18_pkg::IDX_GATE_CONTROL, 2'h0}) begin
        s_d.rdata[7:0] = s_q.gctrl;
      end else if (ra == {tc18_pkg::IDX_COUNTER_STATUS, 2'h0}) begin
        s_d.rdata[tc18_pkg::STAT_RUN_BIT] = running & gate & (mode_f == tc18_pkg::MODE_FREQ);
        s_d.rdata[tc18_pkg::STAT_OVF_BIT] = s_q.overflow_flag;
      end else if (ra == {tc18_pkg::IDX_COMPARE_LOW, 2'h0}) begin
        s_d.rdata[7:0] = s_q.count[7:0];
      end else if (ra == {tc18_pkg::IDX_COMPARE_MIDDLE, 2'h0}) begin
        s_d.rdata[7:0] = s_q.count[15:8];
      end else if (ra == {tc18_pkg::IDX_COMPARE_HIGH, 2'h0}) begin
        s_d.rdata[1:0] = s_q.count[COUNT_W-1:16];
      end else if (ra == {tc18_pkg::IDX_GATE_PERIOD, 2'h0}) begin
        s_d.rdata[7:0] = s_q.period;
      end else if (ra == {tc18_pkg::IDX_CLOCK_CONFIG, 2'h0}) begin
        s_d.rdata[0] = s_q.prescaler_source_bit;
      end else begin
        s_d.rresp = tc18_pkg::AXI_SLVERR;
      end
    end else if (s_q.rvalid && AXI_REQ.rready) begin
      s_d.rvalid = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      s_q        <= '0;
      s_q.ctrl   <= tc18_pkg::COUNTER_CONTROL_RST;
      s_q.gctrl  <= tc18_pkg::GATE_CONTROL_RST;
      s_q.period <= tc18_pkg::GATE_PERIOD_RST;
      s_q.igate  <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    AXI_RSP         = '0;
    AXI_RSP.awready = ~s_q.aw_done;
    AXI_RSP.wready  = ~s_q.w_done;
    AXI_RSP.bvalid  = s_q.bvalid;
    AXI_RSP.bresp   = s_q.bresp;
    AXI_RSP.arready = ~s_q.rvalid;
    AXI_RSP.rvalid  = s_q.rvalid;
    AXI_RSP.rdata   = s_q.rdata;
    AXI_RSP.rresp   = s_q.rresp;
  end

  assign COUNTER_INTERRUPT = s_q.irq;

endmodule : tc18_timer

/* testbench/eighteen_bit_timer_counter_control_tb.sv */
// Self-checking bench for the 18-bit timer/counter.
`timescale 1ns/1ps

`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch %s exp %0h got %0h", n, e, g); end end

module eighteen_bit_timer_counter_control_tb;
  localparam int FS_DIV = 6;
  localparam int PH     = 20;
  logic                sys_clk;
  logic                rst;
  tc18_pkg::axil_req_s req;
  tc18_pkg::axil_rsp_s rsp;
  logic                fs_tick;
  logic                pin;
  logic                pin_on;
  logic                low_power;
  logic                irq;
  int                  num_errors;
  int                  comparisons;
  int                  irqs;
  logic [7:0]          d;
  logic [1:0]          r;

  tc18_timer dut_u (
    .SYS_CLK            (sys_clk),
    .RST                (rst),
    .AXI_REQ            (req),
    .AXI_RSP            (rsp),
    .FS_TICK            (fs_tick),
    .LOW_POWER          (low_power),
    .EXTERNAL_COUNT_PIN (pin),
    .COUNTER_INTERRUPT  (irq)
  );

  tc18_far_side #(.FS_DIV(FS_DIV), .PH(PH)) far_u (
    .clk       (sys_clk),
    .pin_on    (pin_on),
    .fs_tick   (fs_tick),
    .count_pin (pin)
  );

  always #4 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    if (irq === 1'b1) begin
      irqs <= irqs + 1;
    end
  end

  // --------------------------------------------------
  // Bus and helper tasks
  // --------------------------------------------------
  task automatic wr(input logic [7:0] i, input logic [7:0] v);
    req.awaddr <= {22'h0, i, 2'h0};
    req.wdata <= {24'h0, v};
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      req.awvalid <= req.awvalid && !rsp.awready;
      req.wvalid <= req.wvalid && !rsp.wready;
    end while ((req.awvalid && !rsp.awready) || (req.wvalid && !rsp.wready));
    do @(posedge sys_clk); while (rsp.bvalid !== 1'b1);
  endtask : wr

  task automatic rd(input logic [7:0] i, output logic [7:0] v, output logic [1:0] e);
    req.araddr <= {22'h0, i, 2'h0};
    req.arvalid <= 1'b1;
    do @(posedge sys_clk); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge sys_clk); while (rsp.rvalid !== 1'b1);
    v = rsp.rdata[7:0];
    e = rsp.rresp;
  endtask : rd

  task automatic cnt(output logic [17:0] c);
    logic [7:0] l;
    logic [7:0] m;
    rd(tc18_pkg::IDX_COMPARE_LOW, l, r);
    rd(tc18_pkg::IDX_COMPARE_MIDDLE, m, r);
    rd(tc18_pkg::IDX_COMPARE_HIGH, d, r);
    c = {d[1:0], m, l};
  endtask : cnt

  // clock and mode set while stopped
  task automatic go(input logic [2:0] s, input logic [1:0] m);
    wr(tc18_pkg::IDX_COUNTER_CONTROL, {1'b0, tc18_pkg::RUN_STOP, s, m});
    wr(tc18_pkg::IDX_COUNTER_CONTROL, {1'b1, tc18_pkg::RUN_START, s, m});
  endtask : go

  task automatic stop(input logic [2:0] s, input logic [1:0] m);
    wr(tc18_pkg::IDX_COUNTER_CONTROL, {1'b1, tc18_pkg::RUN_STOP, s, m});
  endtask : stop

  task automatic wirq(output longint t);
    do @(posedge sys_clk); while (irq !== 1'b1);
    t = $time;
  endtask : wirq

  task automatic poll(input logic v, output longint t);
    do rd(tc18_pkg::IDX_COUNTER_STATUS, d, r); while (d[7] !== v);
    t = $time;
  endtask : poll

  // --------------------------------------------------
  // Scenarios
  // --------------------------------------------------
  task automatic t_reset;
    rd(tc18_pkg::IDX_COUNTER_CONTROL, d, r);
    `CHK("control", 8'h88, d)
    rd(tc18_pkg::IDX_COUNTER_STATUS, d, r);
    `CHK("status", 8'h00, d)
    rd(8'h30, d, r);
    `CHK("unmapped", tc18_pkg::AXI_SLVERR, r)
  endtask : t_reset

  task automatic t_sources;
    logic [2:0] src [5] = '{3'h6, 3'h5, 3'h1, 3'h7, 3'h4};
    int         unit [5] = '{8, 128, FS_DIV, 2 * PH, 8 * FS_DIV};
    longint     t0;
    longint     t1;
    wr(tc18_pkg::IDX_COMPARE_LOW, 8'h05);
    wr(tc18_pkg::IDX_COMPARE_MIDDLE, 8'h00);
    wr(tc18_pkg::IDX_COMPARE_HIGH, 8'hFC);
    // prescaler bit moves code 100 to low clock
    wr(tc18_pkg::IDX_CLOCK_CONFIG, 8'h01);
    pin_on <= 1'b1;
    // internal codes 110, 101, 001, 100 and the pin (code 111) each drive timer mode
    foreach (src[i]) begin
      go(src[i], tc18_pkg::MODE_TIMER);
      wirq(t0);
      wirq(t1);
      `CHK("period", 5 * unit[i], (t1 - t0) / 8)
      stop(src[i], tc18_pkg::MODE_TIMER);
    end
    wr(tc18_pkg::IDX_CLOCK_CONFIG, 8'h00);
  endtask : t_sources

  task automatic t_inhibit;
    int n;
    wr(tc18_pkg::IDX_COMPARE_LOW, 8'h05);
    go(3'h6, tc18_pkg::MODE_TIMER);
    n = irqs;
    repeat (100) @(posedge sys_clk);
    `CHK("inhibited", n, irqs)
    stop(3'h6, tc18_pkg::MODE_TIMER);
    wr(tc18_pkg::IDX_COMPARE_HIGH, 8'h00);
    go(3'h6, tc18_pkg::MODE_TIMER);
    repeat (60) @(posedge sys_clk);
    `CHK("released", 1'b1, irqs > n)
  endtask : t_inhibit

  task automatic t_clear;
    logic [17:0] c0;
    logic [17:0] c1;
    stop(3'h6, tc18_pkg::MODE_TIMER);
    cnt(c0);
    repeat (50) @(posedge sys_clk);
    cnt(c1);
    `CHK("held", c0, c1)
    wr(tc18_pkg::IDX_COUNTER_CONTROL, {1'b0, tc18_pkg::RUN_STOP, 3'h6, tc18_pkg::MODE_TIMER});
    cnt(c1);
    `CHK("cleared", 18'h0, c1)
  endtask : t_clear

  task automatic t_pulse;
    longint      t;
    logic [17:0] c;
    pin_on <= 1'b0;
    // fast clock only for pulse width
    go(tc18_pkg::SRC_FAST, tc18_pkg::MODE_PULSE);
    pin_on <= 1'b1;
    wirq(t);
    pin_on <= 1'b0;
    cnt(c);
    `CHK("width", 1'b1, c inside {[PH - 1:PH + 1]})
    stop(tc18_pkg::SRC_FAST, tc18_pkg::MODE_PULSE);
  endtask : t_pulse

  task automatic t_freq;
    longint t2;
    longint t3;
    longint t4;
    int     n0;
    int     base;
    wr(tc18_pkg::IDX_GATE_PERIOD, 8'hEF);
    for (int e = 0; e < 3; e++) begin
      // pin clock kept in slow mode
      low_power <= (e == 2);
      base = (e == 2) ? FS_DIV << tc18_pkg::TAP_GFS4 : 1 << tc18_pkg::TAP_GFC12;
      wr(tc18_pkg::IDX_GATE_CONTROL, {3'b001, e[0], 4'b0010});
      go(tc18_pkg::SRC_PIN, tc18_pkg::MODE_FREQ);
      pin_on <= 1'b1;
      poll(1'b1, t2);
      poll(1'b0, t2);
      repeat (16) @(posedge sys_clk);
      n0 = irqs;
      poll(1'b1, t3);
      poll(1'b0, t4);
      repeat (16) @(posedge sys_clk);
      `CHK("gate_low", 1'b1, (t3 - t2) / 8 inside {[base - 8:base + 8]})
      `CHK("gate_high", 1'b1, (t4 - t3) / 8 inside {[2 * base - 8:2 * base + 8]})
      `CHK("edges", e[0] + 1, irqs - n0)
      stop(tc18_pkg::SRC_PIN, tc18_pkg::MODE_FREQ);
      rd(tc18_pkg::IDX_COUNTER_STATUS, d, r);
      `CHK("idle_flag", 1'b0, d[7])
    end
  endtask : t_freq

  task automatic tally_and_finish;
    if (num_errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    req = '0;
    req.wstrb = 4'hF;
    req.bready = 1'b1;
    req.rready = 1'b1;
    pin_on = 1'b0;
    low_power = 1'b0;
    num_errors = 0;
    comparisons = 0;
    irqs = 0;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_reset;
    t_sources;
    t_inhibit;
    t_clear;
    t_pulse;
    t_freq;
    tally_and_finish;
  end

  initial begin
    #(90000 * 8);
    num_errors++;
    tally_and_finish;
  end
endmodule : eighteen_bit_timer_counter_control_tb

/* testbench/tc18_far_side.sv */
// Far-side model: low clock ticks and the external count pin waveform.
`timescale 1ns/1ps

module tc18_far_side #(
  parameter int FS_DIV = 6,
  parameter int PH     = 20
) (
  input  logic clk,
  input  logic pin_on,
  output logic fs_tick,
  output logic count_pin
);
  int fs_q;
  int ph_q;

  initial begin
    fs_q = 0;
    ph_q = 0;
    fs_tick = 1'b0;
    count_pin = 1'b0;
  end

  // The pin rests low between bursts, so a burst always opens with a full low half.
  always @(posedge clk) begin
    fs_q <= (fs_q == FS_DIV - 1) ? 0 : fs_q + 1;
    fs_tick <= (fs_q == FS_DIV - 1);
    if (!pin_on) begin
      ph_q <= 0;
      count_pin <= 1'b0;
    end else if (ph_q == PH - 1) begin
      ph_q <= 0;
      count_pin <= !count_pin;
    end else begin
      ph_q <= ph_q + 1;
    end
  end
endmodule : tc18_far_side

/* testbench/tc18_timer_chk.sv */
// Concurrent checks on the register bus and interrupt of the timer/counter.
`timescale 1ns/1ps

module tc18_timer_chk #(
  parameter int unsigned COUNT_W = tc18_pkg::COUNT_W
) (
  input wire logic                SYS_CLK,
  input wire logic                RST,
  input wire tc18_pkg::axil_req_s AXI_REQ,
  input wire tc18_pkg::axil_rsp_s AXI_RSP,
  input wire logic                FS_TICK,
  input wire logic                LOW_POWER,
  input wire logic                EXTERNAL_COUNT_PIN,
  input wire logic                COUNTER_INTERRUPT
);
  // --------------------------------------------------
  // Helper state: last read index and run request
  // --------------------------------------------------
  logic [7:0] ra_q;
  logic       run_q;

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ra_q  <= 8'h00;
      run_q <= 1'b0;
    end else begin
      if (AXI_REQ.arvalid && AXI_RSP.arready) begin
        ra_q <= AXI_REQ.araddr[9:2];
      end
      if (AXI_REQ.awvalid && AXI_RSP.awready && AXI_REQ.wvalid && AXI_RSP.wready &&
          AXI_REQ.awaddr[9:2] == tc18_pkg::IDX_COUNTER_CONTROL && AXI_REQ.wstrb[0]) begin
        run_q <= AXI_REQ.wdata[6:5] == tc18_pkg::RUN_START;
      end
    end
  end

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);

  sequence wr_taken;
    AXI_REQ.awvalid && AXI_RSP.awready && AXI_REQ.wvalid && AXI_RSP.wready;
  endsequence
  sequence rd_of(logic [7:0] a);
    AXI_RSP.rvalid && ra_q == a;
  endsequence

  // --------------------------------------------------
  // Assertions
  // --------------------------------------------------
  chk_write_answer: assert property (wr_taken |-> ##[1:2] AXI_RSP.bvalid)
    else $error("write response missing");
  chk_read_answer: assert property (AXI_REQ.arvalid && AXI_RSP.arready |=> AXI_RSP.rvalid)
    else $error("read data missing");
  chk_write_hold: assert property (AXI_RSP.bvalid |-> !AXI_RSP.awready && !AXI_RSP.wready)
    else $error("write accepted while response pending");
  chk_read_hold: assert property (AXI_RSP.rvalid |-> !AXI_RSP.arready)
    else $error("read accepted while data pending");
  chk_read_width: assert property (AXI_RSP.rvalid |-> AXI_RSP.rdata[31:8] == 24'h0)
    else $error("read data above byte not zero");
  chk_status_bits: assert property (rd_of(tc18_pkg::IDX_COUNTER_STATUS) |-> AXI_RSP.rdata[5:0] == 6'h0)
    else $error("status low bits not zero");
  chk_high_bits: assert property (rd_of(tc18_pkg::IDX_COMPARE_HIGH) |-> AXI_RSP.rdata[7:2] == 6'h0)
    else $error("compare high byte upper bits not zero");
  chk_clear_self: assert property (rd_of(tc18_pkg::IDX_COUNTER_CONTROL) |-> AXI_RSP.rdata[7])
    else $error("clear bit did not read one");
  chk_flag_idle: assert property (rd_of(tc18_pkg::IDX_COUNTER_STATUS) && !run_q |-> !AXI_RSP.rdata[7])
    else $error("counting flag set while stopped");
  chk_unmapped: assert property (AXI_RSP.rvalid && !(ra_q inside {[8'h14:8'h1B]})
    |-> AXI_RSP.rresp == tc18_pkg::AXI_SLVERR)
    else $error("unmapped read not refused");
  chk_irq_pulse: assert property ($rose(COUNTER_INTERRUPT) |=> !COUNTER_INTERRUPT)
    else $error("interrupt longer than one cycle");
endmodule : tc18_timer_chk

bind tc18_timer tc18_timer_chk #(.COUNT_W(COUNT_W)) chk_u (
  .SYS_CLK            (SYS_CLK),
  .RST                (RST),
  .AXI_REQ            (AXI_REQ),
  .AXI_RSP            (AXI_RSP),
  .FS_TICK            (FS_TICK),
  .LOW_POWER          (LOW_POWER),
  .EXTERNAL_COUNT_PIN (EXTERNAL_COUNT_PIN),
  .COUNTER_INTERRUPT  (COUNTER_INTERRUPT)
);
